// ==== hdl/node_filter_pkg.sv ====
// Constants and carrier types for the per-node request filter.
// Assumes one 100 MHz clock domain shared by all users.
package node_filter_pkg;

	// Byte addresses of the set and clear windows
	localparam logic [11:0] ADR_ASYNC_HIGH_SET = 12'h100;
	localparam logic [11:0] ADR_ASYNC_HIGH_CLR = 12'h104;
	localparam logic [11:0] ADR_ASYNC_LOW_SET  = 12'h108;
	localparam logic [11:0] ADR_ASYNC_LOW_CLR  = 12'h10C;
	localparam logic [11:0] ADR_PHYS_HIGH_SET  = 12'h110;
	localparam logic [11:0] ADR_PHYS_HIGH_CLR  = 12'h114;
	// Distance between consecutive filter windows
	localparam logic [11:0] ADR_FILTER_STRIDE  = 12'h008;
	localparam logic [11:0] ADR_CLR_OFFSET     = 12'h004;

	// Bitmap layout and reset value
	localparam logic [31:0] FILTER_RESET       = 32'h0000_0000;
	localparam int          REMOTE_BIT         = 31;
	// Bits cleared by a bus reset in the physical map
	localparam logic [31:0] PHYS_BUSRST_CLEAR  = 32'h7FFF_FFFF;
	// Node 63 is broadcast and owns no filter bit
	localparam logic [5:0]  NODE_BROADCAST     = 6'h3F;

	// Filter index within the storage array
	localparam int          NUM_FILTERS        = 3;
	localparam int          FILT_ASYNC_HIGH    = 0;
	localparam int          FILT_ASYNC_LOW     = 1;
	localparam int          FILT_PHYS_HIGH     = 2;

	// Incoming request header, as seen by the filter
	typedef struct packed {
		logic       valid;     // One-cycle request strobe
		logic [5:0] src_node;  // Source node number
		logic       local_bus; // Source is on our own bus
		logic       to_phys;   // Packet aims at physical context
	} filter_req_t;

	// Filtering verdict, one cycle after the request
	typedef struct packed {
		logic valid;       // Verdict strobe
		logic ack;         // Acknowledge the packet
		logic queue_async; // Queue to async receive-request context
		logic route_phys;  // Hand to physical request context
	} filter_dec_t;

endpackage

// ==== hdl/node_request_filter.sv ====
// Per-source-node request filter with Wishbone register access.
// Assumes request headers and bus reset arrive from logic on clk.
//
// The Wishbone register port was decided locally.
module node_request_filter (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [11:0]                 wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire node_filter_pkg::filter_req_t req,
	input  wire logic [31:0]                 phys_low_map,
	input  wire logic                        bus_reset_condition,
	output node_filter_pkg::filter_dec_t     dec,
	output logic [31:0]                      async_filter_high,
	output logic [31:0]                      async_filter_low,
	output logic [31:0]                      phys_filter_high
);

	////////////////////////////////////////////////////////////////////
	// Bus slave

	logic [31:0] filt [node_filter_pkg::NUM_FILTERS]; // Filter bitmaps
	logic [31:0] wmask;    // Write data gated by byte selects
	logic        wr_fire;  // Write takes effect this edge
	logic [31:0] next_dat; // Read data for the current address

	// Acknowledge one cycle after the strobe, then drop for one cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Writes land on the edge where the master sees ack
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	// Byte lanes that are not selected leave bits alone
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wmask[8*b +: 8] = wb_dat_i[8*b +: 8] & {8{wb_sel_i[b]}};
	end

	// Read mux: set and clear windows both show the map
	always_comb begin
		unique case (wb_adr_i[11:2])
			node_filter_pkg::ADR_ASYNC_HIGH_SET[11:2],
			node_filter_pkg::ADR_ASYNC_HIGH_CLR[11:2]:
				next_dat = filt[node_filter_pkg::FILT_ASYNC_HIGH];
			node_filter_pkg::ADR_ASYNC_LOW_SET[11:2],
			node_filter_pkg::ADR_ASYNC_LOW_CLR[11:2]:
				next_dat = filt[node_filter_pkg::FILT_ASYNC_LOW];
			node_filter_pkg::ADR_PHYS_HIGH_SET[11:2],
			node_filter_pkg::ADR_PHYS_HIGH_CLR[11:2]:
				next_dat = filt[node_filter_pkg::FILT_PHYS_HIGH];
			// Unmapped words read zero and ignore writes
			default:
				next_dat = 32'h0000_0000;
		endcase
	end

	// Read data is registered together with ack
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= next_dat;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Filter storage, one window pair per map

	for (genvar i = 0; i < node_filter_pkg::NUM_FILTERS; i++) begin : g_filt
		// Window addresses follow the fixed stride
		localparam logic [11:0] SET_ADR = node_filter_pkg::ADR_ASYNC_HIGH_SET
			+ 12'(i) * node_filter_pkg::ADR_FILTER_STRIDE;
		localparam logic [11:0] CLR_ADR = SET_ADR
			+ node_filter_pkg::ADR_CLR_OFFSET;
		logic        set_hit;  // Write to the set window
		logic        clr_hit;  // Write to the clear window
		logic [31:0] rst_mask; // Bits dropped by a bus reset
		logic [31:0] next_map; // Updated bitmap

		assign set_hit = wr_fire && wb_adr_i[11:2] == SET_ADR[11:2];
		assign clr_hit = wr_fire && wb_adr_i[11:2] == CLR_ADR[11:2];
		// Only the physical map loses node bits on bus reset;
		// its remote bit is kept so off-bus peers stay reachable
		assign rst_mask = (i == node_filter_pkg::FILT_PHYS_HIGH
			&& bus_reset_condition)
			? node_filter_pkg::PHYS_BUSRST_CLEAR : 32'h0000_0000;
		// Set is applied last, so a software set beats a clear
		assign next_map = (filt[i] & ~(clr_hit ? wmask : 32'h0000_0000)
			& ~rst_mask) | (set_hit ? wmask : 32'h0000_0000);

		// All maps start empty, so no node gets
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				filt[i] <= node_filter_pkg::FILTER_RESET;
			end else begin
				filt[i] <= next_map;
			end
		end
	end

	// Maps exposed for neighbouring logic
	assign async_filter_high = filt[node_filter_pkg::FILT_ASYNC_HIGH];
	assign async_filter_low  = filt[node_filter_pkg::FILT_ASYNC_LOW];
	assign phys_filter_high  = filt[node_filter_pkg::FILT_PHYS_HIGH];

	////////////////////////////////////////////////////////////////////
	// Per-request decision

	logic [4:0] node_lo;    // Bit index within a 32-node map
	logic       upper_node; // Node 32..63
	logic       node_bcast; // Broadcast node, never matched
	logic       async_hi;   // Upper async bit of the node
	logic       async_lo;   // Lower async bit of the node
	logic       phys_hi;    // Upper physical bit of the node
	logic       phys_lo;    // Lower physical bit of the node
	logic       async_rem;  // Upper async remote bit
	logic       phys_rem;   // Upper physical remote bit
	logic       async_ok;   // Request passes async filter
	logic       phys_ok;    // Request passes physical filter

	assign node_lo    = req.src_node[4:0];
	assign upper_node = req.src_node[5];
	assign node_bcast = req.src_node == node_filter_pkg::NODE_BROADCAST;
	assign async_hi   = async_filter_high[node_lo];
	assign async_lo   = async_filter_low[node_lo];
	assign phys_hi    = phys_filter_high[node_lo];
	assign phys_lo    = phys_low_map[node_lo];
	assign async_rem  = async_filter_high[node_filter_pkg::REMOTE_BIT];
	assign phys_rem   = phys_filter_high[node_filter_pkg::REMOTE_BIT];

	// Node bits count only for same-bus sources
	always_comb begin
		if (!req.local_bus) begin
			// Off-bus sources go by the remote bits
			async_ok = async_rem;
			phys_ok  = phys_rem;
		end else if (upper_node) begin
			// Node k+32 maps to bit k; bit 31 is not a node
			async_ok = async_hi && !node_bcast;
			phys_ok  = phys_hi && !node_bcast;
		end else begin
			// Lower map, same meaning for nodes 0..31
			async_ok = async_lo;
			phys_ok  = phys_lo;
		end
	end

	// Verdict registered one cycle after the header
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dec <= '0;
		end else begin
			dec.valid       <= req.valid;
			// Rejected requests get neither ack nor queue
			dec.ack         <= req.valid && async_ok;
			// Async check first, physical check second
			dec.route_phys  <= req.valid && async_ok && req.to_phys
				&& phys_ok;
			// Failing the physical check falls back to async
			dec.queue_async <= req.valid && async_ok
				&& !(req.to_phys && phys_ok);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic ph_remote; // Physical remote bit, for history checks
	assign ph_remote = filt[node_filter_pkg::FILT_PHYS_HIGH][31];

	sequence low_set_write;
		wr_fire && wb_sel_i == 4'hF
			&& wb_adr_i == node_filter_pkg::ADR_ASYNC_LOW_SET;
	endsequence

	sequence phys_clr_write;
		wr_fire && wb_sel_i == 4'hF
			&& wb_adr_i == node_filter_pkg::ADR_PHYS_HIGH_CLR;
	endsequence

	// Full-word write to the upper async set window
	sequence high_set_write;
		wr_fire && wb_sel_i == 4'hF
			&& wb_adr_i == node_filter_pkg::ADR_ASYNC_HIGH_SET;
	endsequence

	// Full-word write to the lower async clear window
	sequence low_clr_write;
		wr_fire && wb_sel_i == 4'hF
			&& wb_adr_i == node_filter_pkg::ADR_ASYNC_LOW_CLR;
	endsequence

	remote_accept_a: assert property (
		req.valid && !req.local_bus && async_rem |=> dec.ack)
		else $error("remote request not accepted");

	upper_node_a: assert property (
		req.valid && req.local_bus && upper_node && !node_bcast
		&& async_hi |=> dec.ack)
		else $error("enabled upper node not accepted");

	lower_node_a: assert property (
		req.valid && req.local_bus && !upper_node && async_lo
		|=> dec.ack && (dec.queue_async || dec.route_phys))
		else $error("enabled lower node not accepted");

	reject_node_a: assert property (
		req.valid && req.local_bus && !upper_node && !async_lo
		|=> !dec.ack && !dec.queue_async && !dec.route_phys)
		else $error("disabled node got through");

	reset_empty_a: assert property (
		@(posedge clk) disable iff (1'b0)
		!nrst |-> async_filter_low == 32'h0000_0000
		&& phys_filter_high == 32'h0000_0000)
		else $error("filter map not empty in reset");

	low_set_a: assert property (
		low_set_write |=> (async_filter_low & $past(wb_dat_i))
		== $past(wb_dat_i))
		else $error("set window did not set bits");

	phys_clr_a: assert property (
		phys_clr_write
		|=> (phys_filter_high & $past(wb_dat_i)) == 32'h0000_0000)
		else $error("clear window did not clear bits");

	phys_fallback_a: assert property (
		req.valid && req.to_phys && req.local_bus && !upper_node
		&& async_lo && !phys_lo |=> dec.queue_async && !dec.route_phys)
		else $error("physical fallback missing");

	phys_upper_a: assert property (
		req.valid && req.to_phys && req.local_bus && upper_node
		&& !node_bcast && async_hi && phys_hi
		|=> dec.route_phys && !dec.queue_async)
		else $error("upper physical node not routed");

	remote_phys_a: assert property (
		req.valid && !req.local_bus && !phys_rem |=> !dec.route_phys)
		else $error("remote physical routed without bit");

	busrst_keep_a: assert property (
		bus_reset_condition && !wr_fire |=> ph_remote == $past(ph_remote)
		&& phys_filter_high[30:0] == 31'h0000_0000)
		else $error("bus reset handling of physical map wrong");

	ack_pulse_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single-cycle pulse");

	// Upper async set window sets every written one
	high_set_a: assert property (
		high_set_write |=> (async_filter_high & $past(wb_dat_i))
		== $past(wb_dat_i))
		else $error("upper set window did not set bits");

	// Lower async clear window drops every written one
	low_clr_a: assert property (
		low_clr_write
		|=> (async_filter_low & $past(wb_dat_i)) == 32'h0000_0000)
		else $error("lower clear window did not clear bits");

	// Off-bus source with remote bit clear is refused outright
	remote_reject_a: assert property (
		req.valid && !req.local_bus && !async_rem
		|=> !dec.ack && !dec.queue_async && !dec.route_phys)
		else $error("remote request accepted without bit");

	// A physical bit alone never opens the door; async goes first
	phys_after_async_a: assert property (
		req.valid && req.to_phys && req.local_bus && !upper_node
		&& !async_lo && phys_lo |=> !dec.ack && !dec.route_phys)
		else $error("physical route bypassed async check");

	// No verdict without a header, so idle cycles stay quiet
	verdict_idle_a: assert property (
		!req.valid |=> !dec.valid && !dec.ack && !dec.queue_async
		&& !dec.route_phys)
		else $error("verdict without a request");

endmodule

// ==== test/node_source.sv ====
// Model of the remote nodes that send request headers to the filter.
// Assumes the bench calls send() and samples the verdict afterwards.
module node_source (
	input  wire logic                    clk,
	output node_filter_pkg::filter_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Idle from time zero
	initial begin
		req = '0;
	end

	// One header, one cycle; fields are scrambled once it is over so that a
	// filter that reads them late sees garbage, not a lucky match
	task automatic send(input logic [5:0] node, input logic on_bus,
		input logic phys);
		@(posedge clk);
		req <= '{1'b1, node, on_bus, phys};
		@(posedge clk);
		req <= '{1'b0, ~node, ~on_bus, ~phys};
	endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the node request filter.
// Assumes a Wishbone slave that answers each request in its own time.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                         clk;        // 100 MHz clock
	logic                         nrst;       // Active-low reset
	logic                         cyc;        // Bus cycle
	logic                         stb;        // Bus strobe
	logic                         we;         // Write direction
	logic [11:0]                  adr;        // Byte address
	logic [3:0]                   sel;        // Byte lanes
	logic [31:0]                  wdat;       // Write data
	logic [31:0]                  rdat;       // Read data
	logic                         ack;        // Slave answer
	logic [31:0]                  got;        // Last read result
	logic [31:0]                  plow;       // Physical map, nodes 0..31
	logic                         brst;       // Bus reset condition
	logic [31:0]                  afl;        // Lower async map port
	logic [31:0]                  afh;        // Upper async map port
	logic [31:0]                  pfh;        // Upper physical map port
	node_filter_pkg::filter_req_t req;        // Header from the nodes
	node_filter_pkg::filter_dec_t dec;        // Verdict
	int                           num_errors; // Mismatches
	int                           num_checks; // Comparisons
	int                           cycles;     // Hang guard

	node_request_filter dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req(req),
		.phys_low_map(plow), .bus_reset_condition(brst), .dec(dec),
		.async_filter_high(afh), .async_filter_low(afl),
		.phys_filter_high(pfh));
	node_source src (.clk(clk), .req(req));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the whole run needs about a hundred cycles
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 3000) begin
			num_errors++;
			close_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk32(input logic [31:0] g, input logic [31:0] e, input string w);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t %s got %h exp %h", $time, w, g, e);
		end
	endtask

	// One classic cycle; hold until ack is sampled, release at that edge.
	// Values read right after the edge are the ones the edge sampled.
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		// Only the hang guard ends a wait that never gets an answer
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		got = rdat;
		chk32({31'h0, ack}, 32'h1, "bus answer");
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk32(got, e, "read");
	endtask

	// Send one header and compare the verdict one cycle later
	task verdict(input logic [5:0] n, input logic l, input logic p,
		input logic a, input logic q, input logic r);
		src.send(n, l, p);
		#1;
		chk32({28'h0, dec}, {28'h0, 1'b1, a, q, r}, "verdict");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{cyc, stb, we, adr, sel, wdat, plow, brst} = '0;
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(node_filter_pkg::ADR_ASYNC_LOW_SET, 32'h0);
		rd(node_filter_pkg::ADR_PHYS_HIGH_CLR, 32'h0);
		verdict(6'h05, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test reset done");
		wr(node_filter_pkg::ADR_ASYNC_LOW_SET, 32'h8000_0003);
		wr(node_filter_pkg::ADR_ASYNC_LOW_CLR, 32'h0000_0001);
		rd(node_filter_pkg::ADR_ASYNC_LOW_CLR, 32'h8000_0002);
		chk32(afl, 32'h8000_0002, "low map");
		bus(1'b1, node_filter_pkg::ADR_ASYNC_LOW_CLR, 32'hFFFF_FFFF,
			4'h1);
		rd(node_filter_pkg::ADR_ASYNC_LOW_SET, 32'h8000_0000);
		wr(node_filter_pkg::ADR_ASYNC_HIGH_SET, 32'hC000_0001);
		rd(node_filter_pkg::ADR_ASYNC_HIGH_CLR, 32'hC000_0001);
		chk32(afh, 32'hC000_0001, "high map");
		wr(node_filter_pkg::ADR_PHYS_HIGH_SET, 32'h8000_0001);
		rd(node_filter_pkg::ADR_PHYS_HIGH_SET, 32'h8000_0001);
		chk32(pfh, 32'h8000_0001, "phys map");
		wr(12'h200, 32'hFFFF_FFFF);
		rd(12'h200, 32'h0);
		$display("test registers done");
		verdict(6'h1F, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		verdict(6'h1E, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		verdict(6'h3E, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		verdict(6'h3D, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		verdict(6'h3F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		verdict(6'h20, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		verdict(6'h3E, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		verdict(6'h1F, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		@(posedge clk);
		plow <= 32'h8000_0000;
		verdict(6'h1F, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		verdict(6'h05, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		verdict(6'h1E, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		wr(node_filter_pkg::ADR_PHYS_HIGH_CLR, 32'h8000_0000);
		verdict(6'h05, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		wr(node_filter_pkg::ADR_ASYNC_HIGH_CLR, 32'h8000_0000);
		verdict(6'h05, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		$display("test verdicts done");
		wr(node_filter_pkg::ADR_PHYS_HIGH_SET, 32'h8000_0001);
		@(posedge clk);
		brst <= 1'b1;
		@(posedge clk);
		brst <= 1'b0;
		rd(node_filter_pkg::ADR_PHYS_HIGH_SET, 32'h8000_0000);
		chk32(pfh, 32'h8000_0000, "phys map");
		rd(node_filter_pkg::ADR_ASYNC_HIGH_SET, 32'h4000_0001);
		verdict(6'h20, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		// Second reset in mid-run must wipe the maps again
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk32({28'h0, dec}, 32'h0, "verdict after reset");
		rd(node_filter_pkg::ADR_ASYNC_LOW_SET, 32'h0);
		rd(node_filter_pkg::ADR_PHYS_HIGH_SET, 32'h0);
		chk32(pfh, 32'h0, "phys map after reset");
		// Physical bit for node 31 still set by plow, async bit now clear
		verdict(6'h1F, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		$display("test bus reset done");
		close_out;
	end
endmodule
